// ### rtl/amcr_mode_ctrl.v
// Converter mode control and interface options registers behind APB.
// Assumes a converter core that reports results and calibration writes.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "amcr_defines.vh"
module amcr_mode_ctrl #(
    parameter DLY_W = 24
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Converter core
    input wire result_written,
    input wire calib_coef_written,
    input wire data_reg_read,
    input wire channel_switch,
    input wire single_channel,
    input wire sync_pin_in,
    output reg filter_reset,
    output reg conv_start,
    output reg [2:0] op_mode,
    output reg settled_only_output,
    output reg input_enable,
    output reg result_pending_n,
    // Reference, clock, alternate pin control and interrupt
    output reg reference_output_pin_en,
    output reg internal_osc_en,
    output reg [1:0] master_clock_source_select,
    output reg crystal_pin_second_oe,
    output reg crystal_pin_first_en,
    output reg alternate_pin_conversion_control,
    output reg conv_sync_hold,
    output reg irq
);
    // ==========================================================
    // Delay table
    // Counts are worked out as integers and cut to the counter width.
    // The longest needs 18 bits, so a narrower counter would wrap.
    localparam integer N1 = `AMCR_DLY1_NS / `AMCR_PCLK_NS;
    localparam integer N2 = `AMCR_DLY2_NS / `AMCR_PCLK_NS;
    localparam integer N3 = `AMCR_DLY3_NS / `AMCR_PCLK_NS;
    localparam integer N4 = `AMCR_DLY4_NS / `AMCR_PCLK_NS;
    localparam integer N5 = `AMCR_DLY5_NS / `AMCR_PCLK_NS;
    localparam integer N6 = `AMCR_DLY6_NS / `AMCR_PCLK_NS;
    localparam integer N7 = `AMCR_DLY7_NS / `AMCR_PCLK_NS;
    localparam [DLY_W-1:0] C1 = N1[DLY_W-1:0];
    localparam [DLY_W-1:0] C2 = N2[DLY_W-1:0];
    localparam [DLY_W-1:0] C3 = N3[DLY_W-1:0];
    localparam [DLY_W-1:0] C4 = N4[DLY_W-1:0];
    localparam [DLY_W-1:0] C5 = N5[DLY_W-1:0];
    localparam [DLY_W-1:0] C6 = N6[DLY_W-1:0];
    localparam [DLY_W-1:0] C7 = N7[DLY_W-1:0];

    reg [15:0] mode_q;
    reg [15:0] ifopt_q;
    reg [2:0] irq_st_q;
    reg [2:0] irq_mask_q;
    reg [DLY_W-1:0] dly_cycles;
    wire setup_ph;
    wire wr_acc;
    wire hit_mode;
    wire hit_ifopt;
    wire hit_stat;
    wire hit_irq_st;
    wire hit_irq_mask;
    wire wr_ok;
    wire rd_ok;
    wire mode_wr;
    wire [15:0] mode_masked;
    wire ev_result;
    wire ev_calib;
    wire [15:0] mode_new;
    wire [2:0] new_op;
    wire sync_s;
    wire dly_busy;
    wire dly_done;
    wire [2:0] ev;
    wire calib_mode;

    // The slave answers in the cycle after setup, so read data and the
    // error flag are latched at the setup edge to stand with pready.
    assign setup_ph = psel && !penable;
    // Access edge with pready high: the only edge at which a write lands.
    assign wr_acc = psel && penable && pready && pwrite;
    assign hit_mode = paddr == `AMCR_ADDR_MODE;
    assign hit_ifopt = paddr == `AMCR_ADDR_IFOPT;
    assign hit_stat = paddr == `AMCR_ADDR_STAT;
    assign hit_irq_st = paddr == `AMCR_ADDR_IRQ_ST;
    assign hit_irq_mask = paddr == `AMCR_ADDR_IRQ_MASK;
    // The status word is read-only; a write to it is refused like a miss.
    assign wr_ok = hit_mode || hit_ifopt || hit_irq_st || hit_irq_mask;
    assign rd_ok = wr_ok || hit_stat;
    assign mode_wr = wr_acc && hit_mode;
    assign new_op = pwdata[`AMCR_F_OPMODE_HI:`AMCR_F_OPMODE_LO];
    // Reserved code keeps the old mode; other fields still update.
    assign mode_masked = pwdata[15:0] & `AMCR_MODE_WMASK;
    assign mode_new = (new_op == `AMCR_OP_RSVD) ?
        ((mode_masked & 16'hFF8F) | (mode_q & 16'h0070)) :
        mode_masked;
    assign calib_mode = op_mode[2];

    always @* begin
        case (mode_q[`AMCR_F_DELAY_HI:`AMCR_F_DELAY_LO])
            3'h0: dly_cycles = {DLY_W{1'b0}};
            3'h1: dly_cycles = C1;
            3'h2: dly_cycles = C2;
            3'h3: dly_cycles = C3;
            3'h4: dly_cycles = C4;
            3'h5: dly_cycles = C5;
            3'h6: dly_cycles = C6;
            3'h7: dly_cycles = C7;
            default: dly_cycles = {DLY_W{1'b0}};
        endcase
    end

    // ==========================================================
    // Helpers
    amcr_delay_timer #(.W(DLY_W)) u_dly (
        .pclk(pclk),
        .presetn(presetn),
        .start(channel_switch),
        .abort(mode_wr),
        .cycles(dly_cycles),
        .busy(dly_busy),
        .done(dly_done)
    );

    amcr_sync2 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(sync_pin_in),
        .q(sync_s)
    );

    // Events: result ready, calibration done, settling delay done.
    assign ev_result = result_written && !calib_mode;
    assign ev_calib = calib_coef_written && calib_mode;
    assign ev = {dly_done, ev_calib, ev_result};

    // ==========================================================
    // APB response
    // Every access gets one wait-free cycle; the error flag stands with it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph && (pwrite ? !wr_ok : !rd_ok);
        end
    end

    // ==========================================================
    // Read data
    // Taken in the setup cycle so that it stands while pready is high.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            case (paddr)
                `AMCR_ADDR_MODE: prdata <= {16'h0000, mode_q};
                `AMCR_ADDR_IFOPT: prdata <= {16'h0000, ifopt_q};
                `AMCR_ADDR_STAT:
                    prdata <= {28'h0000000, dly_busy, sync_s,
                               input_enable, result_pending_n};
                `AMCR_ADDR_IRQ_ST: prdata <= {29'h00000000, irq_st_q};
                `AMCR_ADDR_IRQ_MASK: prdata <= {29'h00000000, irq_mask_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // Configuration registers
    // Reserved bits are masked off here, so they always read back as zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `AMCR_MODE_RESET;
            ifopt_q <= `AMCR_IFOPT_RESET;
            irq_mask_q <= 3'h0;
        end else if (wr_acc) begin
            if (hit_mode) begin
                mode_q <= mode_new;
            end
            if (hit_ifopt) begin
                ifopt_q <= pwdata[15:0] & `AMCR_IFOPT_WMASK;
            end
            if (hit_irq_mask) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end

    // ==========================================================
    // Interrupt status
    // Set wins over write-one-to-clear, so no event is lost to a clear.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_q <= 3'h0;
        end else if (wr_acc && hit_irq_st) begin
            irq_st_q <= (irq_st_q & ~pwdata[2:0]) | ev;
        end else begin
            irq_st_q <= irq_st_q | ev;
        end
    end

    // ==========================================================
    // Restart strobes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_reset <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            // Code 101 is refused, so it must not restart the filter.
            filter_reset <= mode_wr && new_op != `AMCR_OP_RSVD;
            conv_start <= mode_wr && new_op != `AMCR_OP_RSVD;
        end
    end

    // ==========================================================
    // Result-pending flag
    // A new result in the same cycle as a mode write is dropped:
    // it belongs to the filter run that the write discards.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_pending_n <= 1'b1;
        end else if (mode_wr) begin
            result_pending_n <= 1'b1;
        end else if (ev[0] || ev[1]) begin
            result_pending_n <= 1'b0;
        end else if (data_reg_read) begin
            result_pending_n <= 1'b1;
        end
    end

    // ==========================================================
    // Conversion outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_mode <= `AMCR_OP_CONT;
            settled_only_output <= 1'b0;
            input_enable <= 1'b1;
            alternate_pin_conversion_control <= 1'b0;
            conv_sync_hold <= 1'b0;
        end else begin
            op_mode <= mode_q[`AMCR_F_OPMODE_HI:`AMCR_F_OPMODE_LO];
            settled_only_output <= mode_q[`AMCR_F_SETTLED] &&
                                   single_channel;
            // The switch cycle itself gates input, before busy shows.
            input_enable <= !dly_busy && !channel_switch;
            alternate_pin_conversion_control <=
                ifopt_q[`AMCR_F_ALT_CTRL];
            conv_sync_hold <= ifopt_q[`AMCR_F_ALT_CTRL] && !sync_s;
        end
    end

    // ==========================================================
    // Reference and clock outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_output_pin_en <= 1'b1;
            internal_osc_en <= 1'b1;
            master_clock_source_select <= `AMCR_CLK_INT;
            crystal_pin_second_oe <= 1'b0;
            crystal_pin_first_en <= 1'b0;
        end else begin
            reference_output_pin_en <= mode_q[`AMCR_F_REF_EN];
            master_clock_source_select <=
                mode_q[`AMCR_F_CLKSEL_HI:`AMCR_F_CLKSEL_LO];
            // Codes 00 and 01 both run from the internal oscillator.
            internal_osc_en <= !mode_q[`AMCR_F_CLKSEL_HI];
            crystal_pin_second_oe <= mode_q[3:2] == `AMCR_CLK_INT_OUT;
            crystal_pin_first_en <= mode_q[3:2] == `AMCR_CLK_XTAL;
        end
    end

    // ==========================================================
    // Interrupt output
    // Registered, so the pin lags status by one cycle but never glitches.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_st_q & irq_mask_q);
        end
    end
endmodule // amcr_mode_ctrl

// ### rtl/amcr_defines.vh
// Constants for the converter mode control block: offsets, fields, resets.
// Assumes an APB slave with 32-bit data and a 200 MHz pclk.
`ifndef AMCR_DEFINES_VH
`define AMCR_DEFINES_VH
// ==========================================================
// Register indices and byte addresses
`define AMCR_IDX_MODE 8'h01
`define AMCR_IDX_IFOPT 8'h02
`define AMCR_ADDR_MODE 12'h004
`define AMCR_ADDR_IFOPT 12'h008
`define AMCR_ADDR_STAT 12'h010
`define AMCR_ADDR_IRQ_ST 12'h014
`define AMCR_ADDR_IRQ_MASK 12'h018
`define AMCR_ADDR_EVENT 12'h01C
// ==========================================================
// Reset values and writable masks
`define AMCR_MODE_RESET 16'h8000
`define AMCR_MODE_WMASK 16'hA77C
`define AMCR_IFOPT_RESET 16'h0000
`define AMCR_IFOPT_WMASK 16'h1FFF
// ==========================================================
// Field positions
`define AMCR_F_REF_EN 15
`define AMCR_F_SETTLED 13
`define AMCR_F_DELAY_HI 10
`define AMCR_F_DELAY_LO 8
`define AMCR_F_OPMODE_HI 6
`define AMCR_F_OPMODE_LO 4
`define AMCR_F_CLKSEL_HI 3
`define AMCR_F_CLKSEL_LO 2
`define AMCR_F_ALT_CTRL 12
// ==========================================================
// Operating modes
`define AMCR_OP_CONT 3'h0
`define AMCR_OP_SINGLE 3'h1
`define AMCR_OP_STANDBY 3'h2
`define AMCR_OP_PDOWN 3'h3
`define AMCR_OP_INT_OFS 3'h4
`define AMCR_OP_RSVD 3'h5
`define AMCR_OP_SYS_OFS 3'h6
`define AMCR_OP_SYS_GAIN 3'h7
// Clock sources
`define AMCR_CLK_INT 2'h0
`define AMCR_CLK_INT_OUT 2'h1
`define AMCR_CLK_EXT 2'h2
`define AMCR_CLK_XTAL 2'h3
// ==========================================================
// Settling delays in ns and the pclk period
`define AMCR_PCLK_NS 5
`define AMCR_DLY1_NS 4000
`define AMCR_DLY2_NS 16000
`define AMCR_DLY3_NS 40000
`define AMCR_DLY4_NS 100000
`define AMCR_DLY5_NS 200000
`define AMCR_DLY6_NS 500000
`define AMCR_DLY7_NS 1000000
`endif

// ### rtl/amcr_delay_timer.v
// Settling delay counter started on a channel switch.
// Assumes the caller supplies the length in pclk cycles.
`timescale 1ns/1ps
module amcr_delay_timer #(
    parameter W = 24
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire start,
    input wire abort,
    input wire [W-1:0] cycles,
    output wire busy,
    output reg done
);
    reg [W-1:0] cnt_q;
    reg busy_q;
    assign busy = busy_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= {W{1'b0}};
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy_q <= 1'b0;
            end else if (start) begin
                if (cycles == {W{1'b0}}) begin
                    done <= 1'b1;
                end else begin
                    cnt_q <= cycles - {{(W-1){1'b0}}, 1'b1};
                    busy_q <= 1'b1;
                end
            end else if (busy_q) begin
                if (cnt_q == {W{1'b0}}) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // amcr_delay_timer

// ### rtl/amcr_sync2.v
// Two-flop synchroniser for a level from outside the pclk domain.
// Assumes the input is a slow level; pulses shorter than one cycle may vanish.
`timescale 1ns/1ps
module amcr_sync2 (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Level
    input wire d,
    output reg q
);
    reg meta_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // amcr_sync2

// ### testbench/amcr_mode_ctrl_sva.sv
// Checker for the converter mode control block, bound to its top module.
// Assumes one wait-free APB access cycle and registered outputs.
`timescale 1ns/1ps
`include "amcr_defines.vh"
module amcr_checker (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    // Core
    input wire result_written,
    input wire calib_coef_written,
    input wire data_reg_read,
    input wire filter_reset,
    input wire conv_start,
    input wire [2:0] op_mode,
    input wire result_pending_n,
    input wire reference_output_pin_en,
    input wire internal_osc_en,
    input wire [1:0] master_clock_source_select,
    input wire crystal_pin_second_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pready && pwrite;
    wire mwr = wr && paddr == `AMCR_ADDR_MODE;
    wire go = mwr && pwdata[6:4] != 3'h5;
    // ==========================================================
    // Properties
    property p_start; go |=> filter_reset && conv_start && result_pending_n;
    endproperty
    a_start: assert property (p_start) else $error("no restart");
    property p_cause; conv_start |-> filter_reset && $past(mwr); endproperty
    a_cause: assert property (p_cause) else $error("stray start");
    property p_rsvd; mwr && !go |=> !conv_start ##1 $stable(op_mode);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("code 101 acted");
    property p_op; go |-> ##2 op_mode == $past(pwdata[6:4], 2); endproperty
    a_op: assert property (p_op) else $error("mode field");
    property p_ref;
        mwr |-> ##2 reference_output_pin_en == $past(pwdata[15], 2);
    endproperty
    a_ref: assert property (p_ref) else $error("reference enable");
    property p_osc; mwr |-> ##2 internal_osc_en == !$past(pwdata[3], 2);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable");
    property p_clk;
        mwr |-> ##2 master_clock_source_select == $past(pwdata[3:2], 2)
            && crystal_pin_second_oe == ($past(pwdata[3:2], 2) == 2'h1);
    endproperty
    a_clk: assert property (p_clk) else $error("clock select");
    property p_res; result_written && !op_mode[2] && !data_reg_read && !mwr
        && !filter_reset |=> !result_pending_n; endproperty
    a_res: assert property (p_res) else $error("result flag");
    property p_rd; data_reg_read && !result_written && !calib_coef_written
        && !mwr |=> result_pending_n; endproperty
    a_rd: assert property (p_rd) else $error("read flag");
    property p_cal; calib_coef_written && op_mode[2] && !data_reg_read && !mwr
        && !filter_reset |=> !result_pending_n; endproperty
    a_cal: assert property (p_cal) else $error("calib flag");
    c_go: cover property (go);
    c_cal: cover property (calib_coef_written && op_mode[2]);
    c_err: cover property (pslverr);
endmodule // amcr_checker
bind amcr_mode_ctrl amcr_checker amcr_checker_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .result_written,
    .calib_coef_written, .data_reg_read, .filter_reset, .conv_start, .op_mode,
    .result_pending_n, .reference_output_pin_en, .internal_osc_en,
    .master_clock_source_select, .crystal_pin_second_oe);

// ### testbench/tb.sv
// Self-checking bench for the converter mode control block.
// Assumes the APB slave answers in the first access cycle.
`timescale 1ns/1ps
`include "amcr_defines.vh"
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic single_channel = 1, sync_pin_in = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [3:0] ev = 0;
    wire [31:0] prdata;
    wire [2:0] op_mode;
    wire [1:0] master_clock_source_select;
    wire pready, pslverr, filter_reset, conv_start, settled_only_output;
    wire input_enable, result_pending_n, reference_output_pin_en, irq;
    wire internal_osc_en, crystal_pin_second_oe, crystal_pin_first_en;
    wire alternate_pin_conversion_control, conv_sync_hold;
    int miscompares = 0, check_count = 0, n;
    localparam int DLY = `AMCR_DLY1_NS / `AMCR_PCLK_NS;
    initial forever #2.5 pclk = ~pclk;
    amcr_mode_ctrl amcr_mode_ctrl_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .result_written(ev[0]), .calib_coef_written(ev[1]),
        .data_reg_read(ev[2]), .channel_switch(ev[3]), .single_channel,
        .sync_pin_in, .filter_reset, .conv_start, .op_mode,
        .settled_only_output, .input_enable, .result_pending_n,
        .reference_output_pin_en, .internal_osc_en,
        .master_clock_source_select, .crystal_pin_second_oe,
        .crystal_pin_first_en, .alternate_pin_conversion_control,
        .conv_sync_hold, .irq);
    // ==========================================================
    // Tasks
    task close_out;
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string s);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s %h/%h", $time, s, seen, exp);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            miscompares++;
            close_out;
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e, input string s);
        apb(0, a, 0);
        chk(rd, e, s);
    endtask
    task pulse(input int b);
        @(posedge pclk);
        ev <= 4'h1 << b;
        @(posedge pclk);
        ev <= 4'h0;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        tick(5);
        presetn <= 1;
        rdchk(`AMCR_ADDR_MODE, 32'h8000, "mode rst");
        rdchk(`AMCR_ADDR_IFOPT, 32'h0, "opt rst");
        chk(result_pending_n, 1'b1, "pend rst");
        apb(1, `AMCR_ADDR_MODE, 32'hFFFF);
        tick(3);
        rdchk(`AMCR_ADDR_MODE, 32'hA77C, "rsvd");
        chk({settled_only_output, crystal_pin_first_en}, 2'h3, "b13");
        single_channel <= 0;
        tick(3);
        chk(settled_only_output, 1'b0, "multi");
        apb(1, `AMCR_ADDR_IFOPT, 32'hFFFF);
        rdchk(`AMCR_ADDR_IFOPT, 32'h1FFF, "opt");
        sync_pin_in <= 0;
        tick(6);
        chk({alternate_pin_conversion_control, conv_sync_hold}, 2'h3, "a");
        sync_pin_in <= 1;
        tick(6);
        chk(conv_sync_hold, 1'b0, "sync");
        for (int c = 0; c < 4; c++) begin
            apb(1, `AMCR_ADDR_MODE, c << 2);
            tick(3);
            chk({master_clock_source_select, internal_osc_en,
                crystal_pin_second_oe}, {c[1:0], c < 2, c == 1}, "clk");
        end
        for (int m = 0; m < 8; m++) begin
            apb(1, `AMCR_ADDR_MODE, m << 4);
            tick(3);
            chk(op_mode, (m == 5) ? 3'h4 : m[2:0], "op");
        end
        apb(1, `AMCR_ADDR_MODE, 32'h0);
        pulse(0);
        tick(2);
        chk(result_pending_n, 1'b0, "res");
        pulse(2);
        tick(2);
        chk(result_pending_n, 1'b1, "read");
        apb(1, `AMCR_ADDR_MODE, 32'h40);
        pulse(1);
        tick(2);
        chk(result_pending_n, 1'b0, "cal");
        apb(1, `AMCR_ADDR_MODE, 32'h40);
        tick(2);
        chk(result_pending_n, 1'b1, "rewrite");
        apb(1, `AMCR_ADDR_IRQ_MASK, 32'h4);
        apb(1, `AMCR_ADDR_IRQ_ST, 32'h7);
        apb(1, `AMCR_ADDR_MODE, 32'h100);
        pulse(3);
        tick(2);
        chk(input_enable, 1'b0, "settle");
        rdchk(`AMCR_ADDR_STAT, 32'hD, "stat");
        for (n = 2; n < 2000 && input_enable !== 1'b1; n++) tick(1);
        chk(n > DLY - 6 && n < DLY + 6, 1'b1, "delay");
        tick(2);
        chk(irq, 1'b1, "irq");
        apb(1, `AMCR_ADDR_IRQ_ST, 32'h7);
        pulse(0);
        tick(3);
        chk(irq, 1'b0, "masked");
        apb(0, 12'h020, 32'h0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped");
        close_out;
    end
endmodule // tb
